// ### cfg_msg_regs.svh
// Token codes, field positions and counts for the message-based config access target.
// Assumes byte-wide tokens with a separate control flag; included by bare name.
`ifndef CFG_MSG_REGS_SVH
`define CFG_MSG_REGS_SVH

// Control token values
`define CM_TOK_END     8'h01
`define CM_TOK_ACK     8'h03
`define CM_TOK_NAK     8'h04
`define CM_TOK_CFG_WR  8'hc0
`define CM_TOK_CFG_RD  8'hc1
`define CM_TOK_PER_WR  8'h24
`define CM_TOK_PER_RD  8'h25

// Low byte of return identifier that suppresses a write reply
`define CM_NOREPLY     8'hff

// Processor status resource identifier layout
`define CM_PS_TYPE     8'h0c
`define CM_PS_REG_LSB  8

// Last byte index of each multi-byte field, counted from zero
`define CM_RID_LAST    8'h02
`define CM_CREG_LAST   8'h01
`define CM_CDATA_LAST  8'h03

`endif

// ### cfg_msg_pkg.sv
// Types shared by the config message target, the requester model and the testbench.
// Assumes byte tokens carry a control flag beside the value.
package cfg_msg_pkg;

  // One interconnect token
  typedef struct packed {
    logic       ctrl;   // High for a control token
    logic [7:0] value;  // Data byte or control code
  } token_type;

  // Direct processor status access request
  typedef struct packed {
    logic        valid;     // One-cycle request strobe
    logic        write;     // High for a write
    logic [31:0] resource;  // Register number shifted left 8, ORed with type
    logic [31:0] wdata;     // Write word
  } ps_req_type;

  // Message kinds
  typedef enum logic [1:0] {KIND_CFG_WR, KIND_CFG_RD, KIND_PER_WR, KIND_PER_RD} msg_kind_type;

  // Message engine states
  typedef enum logic [3:0] {
    ST_HEAD, ST_RID, ST_REG, ST_SIZE, ST_DATA, ST_END, ST_COMMIT, ST_ACK, ST_RDATA, ST_TAIL
  } state_type;

endpackage : cfg_msg_pkg

// ### cfg_reg_store.sv
// Simple register array with one write port and one asynchronous read port.
// Assumes the user range-checks addresses; contents have no reset.
`timescale 1ns/1ps
module cfg_reg_store #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 64,
  parameter int AW    = $clog2(DEPTH)
) (
  // Clock
  input  wire logic             ref_clk_in,
  // Write port
  input  wire logic             we_in,
  input  wire logic [AW-1:0]    waddr_in,
  input  wire logic [WIDTH-1:0] wdata_in,
  // Read port
  input  wire logic [AW-1:0]    raddr_in,
  output logic      [WIDTH-1:0] rdata_out
);

  // Storage; no reset so it maps onto plain RAM
  logic [WIDTH-1:0] mem [DEPTH];

  // Refuse shapes the address logic cannot serve
  if (DEPTH < 2 || WIDTH < 1)
  begin : g_bad_shape
    $error("cfg_reg_store: DEPTH must be at least 2");
  end

  // Write on the clock
  always_ff @(posedge ref_clk_in)
  begin
    if (we_in)
    begin
      mem[waddr_in] <= wdata_in;
    end
  end

  // Combinational read, registered by the caller
  assign rdata_out = mem[raddr_in];

endmodule : cfg_reg_store

// ### cfg_msg_target.sv
// Message-based configuration register target plus direct processor status port.
// Assumes a byte token stream with valid/ready handshakes on both directions.
`timescale 1ns/1ps
`include "cfg_msg_regs.svh"

// Summary of operation
// RQ1: Requests carry 24-bit return channel identifier
// RQ2: Low byte all ones on write: no reply
// RQ3: Multi-byte fields travel most significant first
// RQ4: Status resource is register shifted 8, OR 0x0C
// RQ5: Status read and write move one word
// RQ6: Tile config destination ends in C20C
// RQ7: Node config destination ends in C30C
// RQ8: Peripheral destination: node, peripheral, 02
// RQ9: Config write: 192, id, reg16, data32, 1
// RQ10: Config read: 193, id, reg16, 1
// RQ11: Write reply: 3,1 success or 4,1
// RQ12: Config read reply: 3, data32, 1 or 4,1
// RQ13: Peripheral write: 36, id, reg, size, data, 1
// RQ14: Peripheral read: 37, id, reg, size, 1
// RQ15: Peripheral read reply: 3, bytes, 1 or 4,1
// RQ16: Malformed or unknown register fails, no change
module cfg_msg_target
  import cfg_msg_pkg::*;
#(
  parameter int CFG_REGS      = 64,   // Config words reachable by message
  parameter int PER_REGS      = 64,   // Peripheral byte registers
  parameter int PER_MAX_BYTES = 4,    // Largest peripheral transfer
  parameter int PS_REGS       = 256   // Processor status words
) (
  // Clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       srst_in,
  // Incoming message tokens
  input  wire token_type  rx_token_in,
  input  wire logic       rx_valid_in,
  output logic            rx_ready_out,
  // Outgoing reply tokens
  output token_type       tx_token_out,
  output logic            tx_valid_out,
  input  wire logic       tx_ready_in,
  // Direct processor status access
  input  wire ps_req_type ps_req_in,
  output logic            ps_ack_out,
  output logic            ps_err_out,
  output logic [31:0]     ps_rdata_out
);

  localparam int CAW = $clog2(CFG_REGS);
  localparam int PAW = $clog2(PER_REGS);
  localparam int SAW = $clog2(PS_REGS);

  // Refuse sizes the field widths cannot address
  if (CFG_REGS < 2 || CFG_REGS > 65536 || PER_REGS < 2 || PER_REGS > 256 ||
      PS_REGS < 2 || PS_REGS > 256 || PER_MAX_BYTES < 1 || PER_MAX_BYTES > 4)
  begin : g_bad_params
    $error("cfg_msg_target: parameter out of range");
  end

  // Message engine state
  state_type    state_q, state_d;
  msg_kind_type kind_q, kind_d;     // Kind taken from the header token
  logic [23:0]  rid_q, rid_d;       // Return channel identifier
  logic [15:0]  reg_q, reg_d;       // Register number
  logic [7:0]   size_q, size_d;     // Peripheral byte count
  logic [31:0]  data_q, data_d;     // Write data, last four bytes
  logic [7:0]   cnt_q, cnt_d;       // Byte index within a field
  logic         bad_q, bad_d;       // Malformed message seen
  logic         ok_q, ok_d;         // Outcome of the finished message
  logic         rx_ready_q, rx_ready_d;
  logic         tx_valid_q, tx_valid_d;
  token_type    tx_token_q, tx_token_d;

  // Derived terms
  logic         acc;                // Token taken this cycle
  logic         slot_free;          // Reply slot may be loaded
  logic         is_wr, is_cfg, noreply, range_ok, fin;
  logic         cfg_we, per_we;
  logic [31:0]  cfg_rdata;
  logic [7:0]   per_rdata, per_wbyte, per_addr8;
  logic [8:0]   per_span;

  assign acc       = rx_valid_in && rx_ready_q;
  assign slot_free = !tx_valid_q || tx_ready_in;
  assign is_wr     = (kind_q == KIND_CFG_WR) || (kind_q == KIND_PER_WR);
  assign is_cfg    = (kind_q == KIND_CFG_WR) || (kind_q == KIND_CFG_RD);
  assign noreply   = is_wr && (rid_q[7:0] == `CM_NOREPLY);  // RQ2
  assign per_addr8 = reg_q[7:0] + cnt_q;
  assign per_span  = {1'b0, reg_q[7:0]} + {1'b0, size_q};
  // Peripheral bytes were shifted in MSB first, so walk back down
  assign per_wbyte = 8'(data_q >> {(size_q - 8'h01 - cnt_q), 3'b000});  // RQ3
  // End token after the identifier completes the message
  assign fin = acc && (state_q != ST_HEAD) && (state_q != ST_RID) && rx_token_in.ctrl &&
               (rx_token_in.value == `CM_TOK_END);

  // Unknown registers or bad sizes fail the message
  always_comb
  begin
    if (is_cfg)
    begin
      range_ok = ({16'h0000, reg_q} < 32'(CFG_REGS));  // RQ16
    end
    else
    begin
      range_ok = (size_q != 8'h00) && (32'(size_q) <= PER_MAX_BYTES) &&
                 (32'(per_span) <= PER_REGS);  // RQ16
    end
  end

  // Message engine next state
  always_comb
  begin
    state_d    = state_q;
    kind_d     = kind_q;
    rid_d      = rid_q;
    reg_d      = reg_q;
    size_d     = size_q;
    data_d     = data_q;
    cnt_d      = cnt_q;
    bad_d      = bad_q;
    ok_d       = ok_q;
    tx_valid_d = tx_valid_q && !tx_ready_in;
    tx_token_d = tx_token_q;
    cfg_we     = 1'b0;
    per_we     = 1'b0;
    case (state_q)
      ST_HEAD:
      begin
        // Only a known header opens a message; strays are dropped
        if (acc && rx_token_in.ctrl)
        begin
          state_d = ST_RID;
          cnt_d   = 8'h00;
          bad_d   = 1'b0;
          data_d  = 32'h0000_0000;
          reg_d   = 16'h0000;
          size_d  = 8'h00;
          if (rx_token_in.value == `CM_TOK_CFG_WR)
          begin
            kind_d = KIND_CFG_WR;  // RQ9
          end
          else if (rx_token_in.value == `CM_TOK_CFG_RD)
          begin
            kind_d = KIND_CFG_RD;  // RQ10
          end
          else if (rx_token_in.value == `CM_TOK_PER_WR)
          begin
            kind_d = KIND_PER_WR;  // RQ13
          end
          else if (rx_token_in.value == `CM_TOK_PER_RD)
          begin
            kind_d = KIND_PER_RD;  // RQ14
          end
          else
          begin
            state_d = ST_HEAD;
          end
        end
      end
      ST_RID, ST_REG, ST_SIZE, ST_DATA, ST_END:
      begin
        if (fin)
        begin
          // Ending anywhere but after the last field is malformed
          ok_d  = !bad_q && (state_q == ST_END) && range_ok;  // RQ16
          cnt_d = 8'h00;
          if (is_wr && ok_d)
          begin
            state_d = ST_COMMIT;
          end
          else if (noreply)
          begin
            state_d = ST_HEAD;  // RQ2
          end
          else
          begin
            state_d = ST_ACK;
          end
        end
        else if (acc && rx_token_in.ctrl)
        begin
          // No address to reply to yet, or a stray control token
          if (state_q == ST_RID && rx_token_in.value == `CM_TOK_END)
          begin
            state_d = ST_HEAD;
          end
          else
          begin
            bad_d   = 1'b1;
            state_d = ST_END;
          end
        end
        else if (acc)
        begin
          cnt_d = cnt_q + 8'h01;
          if (state_q == ST_RID)
          begin
            rid_d = {rid_q[15:0], rx_token_in.value};  // RQ3
            if (cnt_q == `CM_RID_LAST)
            begin
              state_d = ST_REG;
              cnt_d   = 8'h00;
            end
          end
          else if (state_q == ST_REG)
          begin
            reg_d = {reg_q[7:0], rx_token_in.value};  // RQ3
            if (!is_cfg || cnt_q == `CM_CREG_LAST)
            begin
              cnt_d   = 8'h00;
              state_d = !is_cfg ? ST_SIZE : (is_wr ? ST_DATA : ST_END);
            end
          end
          else if (state_q == ST_SIZE)
          begin
            size_d  = rx_token_in.value;
            cnt_d   = 8'h00;
            state_d = (is_wr && rx_token_in.value != 8'h00) ? ST_DATA : ST_END;
          end
          else if (state_q == ST_DATA)
          begin
            // Only four bytes fit; longer bursts fail the range check
            data_d = {data_q[23:0], rx_token_in.value};  // RQ3
            if (cnt_q == (is_cfg ? `CM_CDATA_LAST : size_q - 8'h01))
            begin
              state_d = ST_END;
            end
          end
          else
          begin
            bad_d = 1'b1;  // RQ16
          end
        end
      end
      ST_COMMIT:
      begin
        // Writes land only after the whole message checked out
        cfg_we = is_cfg;  // RQ9
        per_we = !is_cfg;  // RQ13
        cnt_d  = cnt_q + 8'h01;
        if (is_cfg || cnt_q == size_q - 8'h01)
        begin
          cnt_d   = 8'h00;
          state_d = noreply ? ST_HEAD : ST_ACK;  // RQ2
        end
      end
      ST_ACK:
      begin
        if (slot_free)
        begin
          tx_valid_d = 1'b1;
          tx_token_d = '{ctrl: 1'b1, value: ok_q ? `CM_TOK_ACK : `CM_TOK_NAK};  // RQ11
          state_d    = (ok_q && !is_wr) ? ST_RDATA : ST_TAIL;  // RQ12
        end
      end
      ST_RDATA:
      begin
        if (slot_free)
        begin
          tx_valid_d = 1'b1;
          tx_token_d = '{ctrl: 1'b0,
                         value: is_cfg ? 8'(cfg_rdata >> {~cnt_q[1:0], 3'b000})
                                       : per_rdata};  // RQ15
          cnt_d      = cnt_q + 8'h01;
          if (cnt_q == (is_cfg ? `CM_CDATA_LAST : size_q - 8'h01))
          begin
            state_d = ST_TAIL;
          end
        end
      end
      ST_TAIL:
      begin
        if (slot_free)
        begin
          tx_valid_d = 1'b1;
          tx_token_d = '{ctrl: 1'b1, value: `CM_TOK_END};  // RQ11
          state_d    = ST_HEAD;
        end
      end
      default:
      begin
        state_d = ST_HEAD;
      end
    endcase
    // Accept tokens only while parsing; replies hold the input off
    rx_ready_d = (state_d == ST_HEAD) || (state_d == ST_RID) || (state_d == ST_REG) ||
                 (state_d == ST_SIZE) || (state_d == ST_DATA) || (state_d == ST_END);
  end

  // Message engine registers
  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      state_q    <= ST_HEAD;
      kind_q     <= KIND_CFG_WR;
      rid_q      <= 24'h00_0000;
      reg_q      <= 16'h0000;
      size_q     <= 8'h00;
      data_q     <= 32'h0000_0000;
      cnt_q      <= 8'h00;
      bad_q      <= 1'b0;
      ok_q       <= 1'b0;
      rx_ready_q <= 1'b0;
      tx_valid_q <= 1'b0;
      tx_token_q <= '{ctrl: 1'b0, value: 8'h00};
    end
    else
    begin
      state_q    <= state_d;
      kind_q     <= kind_d;
      rid_q      <= rid_d;
      reg_q      <= reg_d;
      size_q     <= size_d;
      data_q     <= data_d;
      cnt_q      <= cnt_d;
      bad_q      <= bad_d;
      ok_q       <= ok_d;
      rx_ready_q <= rx_ready_d;
      tx_valid_q <= tx_valid_d;
      tx_token_q <= tx_token_d;
    end
  end

  assign rx_ready_out = rx_ready_q;
  assign tx_valid_out = tx_valid_q;
  assign tx_token_out = tx_token_q;

  // Config word store for tile and node registers
  cfg_reg_store #(.WIDTH(32), .DEPTH(CFG_REGS)) u_cfg_store (
    .ref_clk_in (ref_clk_in),
    .we_in      (cfg_we),
    .waddr_in   (reg_q[CAW-1:0]),
    .wdata_in   (data_q),
    .raddr_in   (reg_q[CAW-1:0]),
    .rdata_out  (cfg_rdata)
  );

  // Peripheral byte store
  cfg_reg_store #(.WIDTH(8), .DEPTH(PER_REGS)) u_per_store (
    .ref_clk_in (ref_clk_in),
    .we_in      (per_we),
    .waddr_in   (per_addr8[PAW-1:0]),
    .wdata_in   (per_wbyte),
    .raddr_in   (per_addr8[PAW-1:0]),
    .rdata_out  (per_rdata)
  );

  // Direct processor status port
  logic        ps_ok, ps_we;
  logic        ps_ack_q, ps_ack_d, ps_err_q, ps_err_d;
  logic [31:0] ps_rdata_q, ps_rdata_d, ps_rd;

  // Resource must carry the status type and a known register
  assign ps_ok = (ps_req_in.resource[7:0] == `CM_PS_TYPE) &&
                 (ps_req_in.resource[31:16] == 16'h0000) &&
                 (32'(ps_req_in.resource[15:`CM_PS_REG_LSB]) < PS_REGS);
  assign ps_we = ps_req_in.valid && ps_req_in.write && ps_ok;  // RQ5

  // One-cycle answer; a whole word either way
  always_comb
  begin
    ps_ack_d   = ps_req_in.valid;
    ps_err_d   = ps_req_in.valid && !ps_ok;
    ps_rdata_d = (ps_req_in.valid && !ps_req_in.write && ps_ok) ? ps_rd : 32'h0000_0000;  // RQ5
  end

  // Status port registers
  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      ps_ack_q   <= 1'b0;
      ps_err_q   <= 1'b0;
      ps_rdata_q <= 32'h0000_0000;
    end
    else
    begin
      ps_ack_q   <= ps_ack_d;
      ps_err_q   <= ps_err_d;
      ps_rdata_q <= ps_rdata_d;
    end
  end

  assign ps_ack_out   = ps_ack_q;
  assign ps_err_out   = ps_err_q;
  assign ps_rdata_out = ps_rdata_q;

  // Processor status word store
  cfg_reg_store #(.WIDTH(32), .DEPTH(PS_REGS)) u_ps_store (
    .ref_clk_in (ref_clk_in),
    .we_in      (ps_we),
    .waddr_in   (ps_req_in.resource[`CM_PS_REG_LSB +: SAW]),
    .wdata_in   (ps_req_in.wdata),
    .raddr_in   (ps_req_in.resource[`CM_PS_REG_LSB +: SAW]),
    .rdata_out  (ps_rd)
  );

  // Checks
  a_noreply_write: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RQ2
    (fin && is_wr && rid_q[7:0] == `CM_NOREPLY) |=> (state_q inside {ST_COMMIT, ST_HEAD}))
    else $error("reply scheduled for a suppressed write");
  a_ack_code: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RQ11
    (state_q == ST_ACK && slot_free) |=> (tx_valid_q && tx_token_q.ctrl &&
      tx_token_q.value == (ok_q ? `CM_TOK_ACK : `CM_TOK_NAK)))
    else $error("wrong acknowledge token");
  a_read_data_follows: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RQ12
    (state_q == ST_ACK && slot_free && ok_q && !is_wr) |=> (state_q == ST_RDATA))
    else $error("successful read not followed by data");
  a_msb_first: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RQ3
    (state_q == ST_RDATA && slot_free && is_cfg && cnt_q == 8'h00) |=>
      (tx_token_q.value == cfg_rdata[31:24] && !tx_token_q.ctrl))
    else $error("config read data not most significant first");
  a_per_byte: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RQ15
    (state_q == ST_RDATA && slot_free && !is_cfg) |=> (tx_token_q.value == $past(per_rdata)))
    else $error("peripheral read byte mismatch");
  a_bad_fails: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RQ16
    (fin && bad_q) |=> !ok_q ##1 !(cfg_we || per_we))
    else $error("malformed message reported success");
  a_cfg_write: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RQ9
    cfg_we |=> (cfg_rdata == $past(data_q) && ok_q))
    else $error("config write did not store data");
  a_read_head: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RQ10
    (state_q == ST_HEAD && acc && rx_token_in.ctrl && rx_token_in.value == `CM_TOK_CFG_RD)
      |=> (state_q == ST_RID && kind_q == KIND_CFG_RD))
    else $error("config read header not taken");
  a_ps_answer: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RQ5
    (ps_req_in.valid && ps_ok) |=> (ps_ack_q && !ps_err_q))
    else $error("status access not answered");

endmodule : cfg_msg_target

// ### cfg_requester.sv
// Requesting channel-end model: sends queued message tokens and collects reply tokens.
// Assumes the testbench fills send_q and reads got_q by hierarchical reference.
`timescale 1ns/1ps
module cfg_requester
  import cfg_msg_pkg::*;
(
  // Clock, reset and pacing
  input  wire logic      ref_clk_in,
  input  wire logic      srst_in,
  input  wire logic      slow_in,
  // Request tokens toward the target
  output token_type      req_token_out,
  output logic           req_valid_out,
  input  wire logic      req_ready_in,
  // Reply tokens from the target
  input  wire token_type rsp_token_in,
  input  wire logic      rsp_valid_in,
  output logic           rsp_ready_out
);
  token_type  send_q[$];  // Tokens still to send
  token_type  got_q[$];   // Reply tokens received
  logic [1:0] tick_q;     // Pacing count for slow mode

  // A token is held until taken; a released line shows the inverse, then toggles every cycle until the next token
  always @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      // Idle line state while the target is held in reset
      tick_q        <= 2'h0;
      rsp_ready_out <= 1'b0;
      req_token_out <= '0;
      req_valid_out <= 1'b0;
    end
    else
    begin
      tick_q        <= tick_q + 2'h1;
      rsp_ready_out <= !slow_in || tick_q[0];
      if (rsp_valid_in && rsp_ready_out)
        got_q.push_back(rsp_token_in);
      if (!req_valid_out || req_ready_in)
      begin
        // Slow mode leaves gaps between tokens
        if (send_q.size() > 0 && (!slow_in || tick_q[0]))
        begin
          req_token_out <= send_q.pop_front();
          req_valid_out <= 1'b1;
        end
        else
        begin
          req_token_out <= ~req_token_out;
          req_valid_out <= 1'b0;
        end
      end
    end
  end
endmodule : cfg_requester

// ### tb_top.sv
// Self-checking bench for the config message target and its status port.
// Assumes the requester model sits on the message link; no other partner.
`timescale 1ns/1ps
`include "cfg_msg_regs.svh"
`define CHECK(what, exp, got) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("unexpected %s: expected %h seen %h", what, exp, got); \
    end \
  end
module tb_top
  import cfg_msg_pkg::*;
;
  localparam logic [23:0] RET_ID = 24'h01_2345;
  localparam logic [31:0] PS_RES = (32'h0000_0003 << 8) | 32'h0000_000c;
  localparam logic [31:0] TILE_DST = 32'h0001_c20c;
  localparam logic [31:0] NODE_DST = 32'h0001_c30c;
  localparam logic [31:0] PER_DST  = 32'h0001_0502;

  logic        ref_clk_in;   // 100 MHz clock
  logic        srst_in;      // Synchronous reset
  logic        slow;         // Partner pacing
  token_type   rx_token;     // Request token
  logic        rx_valid;     // Request valid
  logic        rx_ready;     // Target ready
  token_type   tx_token;     // Reply token
  logic        tx_valid;     // Reply valid
  logic        tx_ready;     // Partner ready
  ps_req_type  ps_req;       // Status request
  logic        ps_ack;       // Status answer
  logic        ps_err;       // Status refusal
  logic [31:0] ps_rdata;     // Status read word
  int          fail_count;   // Mismatches
  int          n_compared;   // Comparisons made
  token_type   exp_q[$];     // Expected reply

  cfg_msg_target u_cfg_msg_target (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
    .rx_token_in(rx_token), .rx_valid_in(rx_valid), .rx_ready_out(rx_ready),
    .tx_token_out(tx_token), .tx_valid_out(tx_valid), .tx_ready_in(tx_ready),
    .ps_req_in(ps_req), .ps_ack_out(ps_ack), .ps_err_out(ps_err), .ps_rdata_out(ps_rdata));

  cfg_requester u_cfg_requester (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .slow_in(slow),
    .req_token_out(rx_token), .req_valid_out(rx_valid), .req_ready_in(rx_ready),
    .rsp_token_in(tx_token), .rsp_valid_in(tx_valid), .rsp_ready_out(tx_ready));

  // Clock generator
  initial
  begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  // Verdict and end of run
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  // Queue n bytes of v, most significant first, toward the target
  task automatic put(input logic c, input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--)
      u_cfg_requester.send_q.push_back({c, v[i*8 +: 8]});
  endtask : put

  // Add n bytes of v, most significant first, to the expected reply
  task automatic want(input logic c, input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--)
      exp_q.push_back({c, v[i*8 +: 8]});
  endtask : want

  // Success reply with n data bytes; failure reply
  task automatic ok_reply(input logic [31:0] d, input int n);
    want(1'b1, `CM_TOK_ACK, 1);
    want(1'b0, d, n);
    want(1'b1, `CM_TOK_END, 1);
  endtask : ok_reply
  task automatic nak_reply;
    want(1'b1, `CM_TOK_NAK, 1);
    want(1'b1, `CM_TOK_END, 1);
  endtask : nak_reply

  // Tile or node config message; data only for a write
  task automatic cfg_msg(input logic [7:0] hdr, input logic [23:0] id, input logic [15:0] rg,
                         input logic [31:0] d);
    put(1'b1, hdr, 1);
    put(1'b0, id, 3);
    put(1'b0, rg, 2);
    if (hdr == `CM_TOK_CFG_WR)
      put(1'b0, d, 4);
    put(1'b1, `CM_TOK_END, 1);
  endtask : cfg_msg

  // Peripheral message with n data bytes
  task automatic per_msg(input logic [7:0] hdr, input logic [7:0] rg, input logic [7:0] sz,
                         input logic [31:0] d, input int n);
    put(1'b1, hdr, 1);
    put(1'b0, RET_ID, 3);
    put(1'b0, rg, 1);
    put(1'b0, sz, 1);
    put(1'b0, d, n);
    put(1'b1, `CM_TOK_END, 1);
  endtask : per_msg

  // Wait for the expected reply (bounded), allow stray extras to show, then compare
  task automatic check_reply(input string what);
    int got_n;
    for (int k = 0; k < 300; k++)
    begin
      @(posedge ref_clk_in);
      if (exp_q.size() > 0 && u_cfg_requester.got_q.size() >= exp_q.size())
        break;
    end
    repeat (4) @(posedge ref_clk_in);
    got_n = u_cfg_requester.got_q.size();
    `CHECK({what, " count"}, exp_q.size(), got_n)
    foreach (exp_q[i])
      if (i < got_n)
        `CHECK(what, exp_q[i], u_cfg_requester.got_q[i])
    exp_q.delete();
    u_cfg_requester.got_q.delete();
  endtask : check_reply

  // Config write then read back, MSB-first word
  task automatic t_cfg;
    cfg_msg(`CM_TOK_CFG_WR, RET_ID, 16'h0005, 32'h1234_5678);
    ok_reply(32'h0, 0);
    check_reply("config write reply");
    cfg_msg(`CM_TOK_CFG_RD, RET_ID, 16'h0005, 32'h0);
    ok_reply(32'h1234_5678, 4);
    check_reply("config read reply");
    $display("test cfg done, tile dest %h", TILE_DST);
  endtask : t_cfg

  // Write with all-ones low id byte: silent, yet stored
  task automatic t_silent;
    cfg_msg(`CM_TOK_CFG_WR, {RET_ID[23:8], 8'hff}, 16'h0006, 32'hcafe_f00d);
    check_reply("suppressed write reply");
    cfg_msg(`CM_TOK_CFG_RD, RET_ID, 16'h0006, 32'h0);
    ok_reply(32'hcafe_f00d, 4);
    check_reply("suppressed write data");
    $display("test silent done");
  endtask : t_silent

  // Unknown config registers fail and leave contents alone
  task automatic t_cfg_fail;
    cfg_msg(`CM_TOK_CFG_RD, RET_ID, 16'h0040, 32'h0);
    nak_reply();
    check_reply("config bad read");
    cfg_msg(`CM_TOK_CFG_WR, RET_ID, 16'h0105, 32'h0);
    nak_reply();
    check_reply("config bad write");
    cfg_msg(`CM_TOK_CFG_WR, {RET_ID[23:8], 8'hff}, 16'h0105, 32'h0);
    check_reply("suppressed bad write");
    put(1'b1, `CM_TOK_CFG_RD, 1);
    put(1'b0, RET_ID, 2);
    put(1'b1, `CM_TOK_END, 1);
    check_reply("early end dropped");
    cfg_msg(`CM_TOK_CFG_RD, RET_ID, 16'h0005, 32'h0);
    ok_reply(32'h1234_5678, 4);
    check_reply("config unchanged");
    $display("test cfg_fail done, node dest %h", NODE_DST);
  endtask : t_cfg_fail

  // Peripheral bytes with a stalling partner, back-to-back reads
  task automatic t_per;
    slow <= 1'b1;
    per_msg(`CM_TOK_PER_WR, 8'h0a, 8'h03, 32'h00a1_b2c3, 3);
    ok_reply(32'h0, 0);
    check_reply("periph write reply");
    per_msg(`CM_TOK_PER_RD, 8'h0a, 8'h03, 32'h0, 0);
    ok_reply(32'h00a1_b2c3, 3);
    check_reply("periph read reply");
    per_msg(`CM_TOK_PER_RD, 8'h0b, 8'h01, 32'h0, 0);
    per_msg(`CM_TOK_PER_RD, 8'h0c, 8'h01, 32'h0, 0);
    ok_reply(32'h0000_00b2, 1);
    ok_reply(32'h0000_00c3, 1);
    check_reply("periph back to back");
    slow <= 1'b0;
    $display("test per done, periph dest %h", PER_DST);
  endtask : t_per

  // Bad peripheral sizes and extra bytes fail without writing
  task automatic t_per_fail;
    per_msg(`CM_TOK_PER_RD, 8'h0a, 8'h05, 32'h0, 0);
    nak_reply();
    check_reply("periph oversize");
    per_msg(`CM_TOK_PER_WR, 8'h0a, 8'h01, 32'h0000_5566, 2);
    nak_reply();
    check_reply("periph extra byte");
    per_msg(`CM_TOK_PER_WR, 8'h3e, 8'h04, 32'h0102_0304, 4);
    nak_reply();
    check_reply("periph past end");
    per_msg(`CM_TOK_PER_RD, 8'h0a, 8'h01, 32'h0, 0);
    ok_reply(32'h0000_00a1, 1);
    check_reply("periph unchanged");
    $display("test per_fail done");
  endtask : t_per_fail

  // One status access; ack comes the cycle after the strobe
  task automatic ps(input logic wr, input logic [31:0] res, input logic [31:0] wd,
                    input logic err, input logic [31:0] rd);
    @(posedge ref_clk_in);
    ps_req <= '{valid: 1'b1, write: wr, resource: res, wdata: wd};
    @(posedge ref_clk_in);
    ps_req.valid <= 1'b0;
    #1;
    `CHECK("status ack", 1'b1, ps_ack)
    `CHECK("status error", err, ps_err)
    `CHECK("status read word", rd, ps_rdata)
  endtask : ps

  // Status words by resource identifier, refusals included
  task automatic t_status;
    ps(1'b1, PS_RES, 32'hdead_beef, 1'b0, 32'h0);
    ps(1'b0, PS_RES, 32'h0, 1'b0, 32'hdead_beef);
    ps(1'b1, PS_RES ^ 32'h0000_0001, 32'h1, 1'b1, 32'h0);
    ps(1'b0, PS_RES | 32'h0001_0000, 32'h0, 1'b1, 32'h0);
    ps(1'b0, PS_RES, 32'h0, 1'b0, 32'hdead_beef);
    $display("test status done");
  endtask : t_status

  // Main sequence
  initial
  begin
    fail_count = 0;
    n_compared = 0;
    srst_in    = 1'b1;
    slow       = 1'b0;
    ps_req     = '0;
    repeat (6) @(posedge ref_clk_in);
    srst_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    t_cfg();
    t_silent();
    t_cfg_fail();
    t_per();
    t_per_fail();
    t_status();
    finish_test();
  end

  // Watchdog, well beyond the bounded waits of all tests
  initial
  begin
    repeat (20000) @(posedge ref_clk_in);
    fail_count++;
    $display("watchdog expired");
    finish_test();
  end
endmodule : tb_top
